// *** verilog/smsc_device.sv ***
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module smsc_device
    import smsc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Processor bus
    smsc_bus_if.device       bus,
    // Pins
    input  wire logic        framePin,
    input  wire logic        outputDriveEnablePin,
    // Serial output control
    output logic [15:0]      serialOutEnable,
    output logic [1:0]       serialRate,
    output logic [6:0]       channelMask,
    // Offset measurement
    output logic             evalRunning,
    input  wire logic        measDone,
    input  wire logic [11:0] measOffset,
    // Connection memory fill port
    output logic             cmWrite,
    output logic [10:0]      cmAddr,
    output logic [15:0]      cmData,
    output logic             fillBusy
);
    // ****************************************************************
    // Types and state
    // ****************************************************************
    typedef enum logic [1:0] {
        SMSC_F_IDLE, SMSC_F_ALIGN, SMSC_F_RUN
    } smsc_fill_t;

    smsc_fill_t  fillState;
    logic [15:0] ctrlReg;
    logic [15:0] imsReg;
    logic [1:0]  frameSync;
    logic [1:0]  odeSync;
    logic        framePrev;
    logic        frameEdge;
    logic        frameCnt;
    logic [3:0]  walkStream;
    logic [6:0]  walkChan;
    logic        walkDone;
    logic        startPrev;
    logic        measPrev;
    logic        evalDone;
    logic [11:0] evalOffset;
    logic        wrIms;
    logic        wrCtrl;
    logic        beginRise;
    logic        abortFill;
    logic        fillEnd;
    logic        startRise;
    logic        startFall;
    logic        measRise;

    // Register address match, used by read and write decode
    function automatic logic isAddr(input logic [7:0] a,
                                    input logic [7:0] r);
        isAddr = (a == r);
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Two flops per pin before any logic
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            frameSync <= 2'h0;
            odeSync   <= 2'h0;
        end else if (ce) begin
            frameSync <= {frameSync[0], framePin};
            odeSync   <= {odeSync[0], outputDriveEnablePin};
        end
    end

    // Frame pulse edge from the second stage only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            framePrev <= 1'b0;
        end else if (ce) begin
            framePrev <= frameSync[1];
        end
    end
    assign frameEdge      = frameSync[1] & ~framePrev;
    assign bus.framePulse = frameEdge;

    // ****************************************************************
    // Decode and events
    // ****************************************************************
    assign wrIms  = bus.cs & bus.we & isAddr(bus.addr, SMSC_ADDR_IMS);
    assign wrCtrl = bus.cs & bus.we & isAddr(bus.addr, SMSC_ADDR_CONTROL);
    assign beginRise = wrIms & bus.wrData[SMSC_BEGIN_BIT]
                     & ~imsReg[SMSC_BEGIN_BIT]
                     & ctrlReg[SMSC_READY_BIT];
    assign abortFill = (fillState != SMSC_F_IDLE)
                     & ((wrIms & ~bus.wrData[SMSC_BEGIN_BIT])
                      | (wrCtrl & ~bus.wrData[SMSC_READY_BIT]));
    assign fillEnd   = (fillState == SMSC_F_RUN) & frameEdge
                     & (frameCnt == 1'(SMSC_FILL_FRAMES - 1));
    assign startRise = imsReg[SMSC_EVAL_BIT] & ~startPrev;
    assign startFall = ~imsReg[SMSC_EVAL_BIT] & startPrev;
    assign measRise  = measDone & ~measPrev;

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Control register: only the used low bits are kept
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrlReg <= SMSC_RESET_VALUE;
        end else if (ce && wrCtrl) begin
            ctrlReg <= {{(16-SMSC_CTRL_USED){1'b0}},
                        bus.wrData[SMSC_CTRL_USED-1:0]};
        end
    end

    // Mode register; begin bit self-clears, a write wins over it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            imsReg <= SMSC_RESET_VALUE;
        end else if (ce) begin
            if (wrIms) begin
                imsReg <= {{(16-SMSC_IMS_USED){1'b0}},
                           bus.wrData[SMSC_IMS_USED-1:0]};
            end else if (fillEnd) begin
                imsReg[SMSC_BEGIN_BIT] <= 1'b0;
            end else if (wrCtrl && !bus.wrData[SMSC_READY_BIT]) begin
                imsReg[SMSC_BEGIN_BIT] <= 1'b0;
            end
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus.ack    <= 1'b0;
            bus.rdData <= SMSC_RESET_VALUE;
        end else if (ce) begin
            bus.ack    <= bus.cs;
            bus.rdData <= SMSC_RESET_VALUE;
            if (bus.cs && !bus.we) begin
                if (isAddr(bus.addr, SMSC_ADDR_CONTROL)) begin
                    bus.rdData <= ctrlReg;
                end else if (isAddr(bus.addr, SMSC_ADDR_IMS)) begin
                    bus.rdData <= imsReg;
                end else if (isAddr(bus.addr, SMSC_ADDR_FAR)) begin
                    bus.rdData <= {3'h0, evalDone, evalOffset};
                end
            end
        end
    end

    // ****************************************************************
    // Block fill sequencer
    // ****************************************************************
    // Align to a frame, then run two complete frames
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fillState <= SMSC_F_IDLE;
            frameCnt  <= 1'b0;
        end else if (ce) begin
            case (fillState)
                SMSC_F_IDLE: begin
                    frameCnt <= 1'b0;
                    if (beginRise) begin
                        fillState <= SMSC_F_ALIGN;
                    end
                end
                SMSC_F_ALIGN: begin
                    if (abortFill) begin
                        fillState <= SMSC_F_IDLE;
                    end else if (frameEdge) begin
                        fillState <= SMSC_F_RUN;
                    end
                end
                SMSC_F_RUN: begin
                    if (abortFill || fillEnd) begin
                        fillState <= SMSC_F_IDLE;
                    end else if (frameEdge) begin
                        frameCnt <= ~frameCnt;
                    end
                end
                default: fillState <= SMSC_F_IDLE;
            endcase
        end
    end

    // Walk every stream and every channel valid at the rate
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            walkStream <= 4'h0;
            walkChan   <= 7'h00;
            walkDone   <= 1'b0;
        end else if (ce) begin
            if (fillState != SMSC_F_RUN || frameEdge) begin
                walkStream <= 4'h0;
                walkChan   <= 7'h00;
                walkDone   <= 1'b0;
            end else if (!walkDone) begin
                if (walkChan == channelMask) begin
                    walkChan <= 7'h00;
                    walkStream <= walkStream + 4'h1;
                    walkDone <= (walkStream == 4'(SMSC_STREAMS - 1));
                end else begin
                    walkChan <= walkChan + 7'h01;
                end
            end
        end
    end

    // Memory write port
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmWrite <= 1'b0;
            cmAddr  <= 11'h000;
            cmData  <= 16'h0000;
        end else if (ce) begin
            cmWrite <= (fillState == SMSC_F_RUN) & ~walkDone
                     & ~abortFill & ~frameEdge;
            cmAddr  <= {walkStream, walkChan};
            cmData  <= {imsReg[SMSC_FILL_HI:SMSC_FILL_LO],
                        {SMSC_CM_LO_W{1'b0}}};
        end
    end
    assign fillBusy = (fillState != SMSC_F_IDLE);

    // ****************************************************************
    // Offset evaluation
    // ****************************************************************
    // Start on rise, stop on done rise, clear results on start fall
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            startPrev   <= 1'b0;
            measPrev    <= 1'b0;
            evalRunning <= 1'b0;
            evalDone    <= 1'b0;
            evalOffset  <= 12'h000;
        end else if (ce) begin
            startPrev <= imsReg[SMSC_EVAL_BIT];
            measPrev  <= measDone;
            if (startRise) begin
                evalRunning <= 1'b1;
            end else if (measRise || startFall) begin
                evalRunning <= 1'b0;
            end
            if (evalRunning && measRise) begin
                evalDone   <= 1'b1;
                evalOffset <= measOffset;
            end else if (startFall) begin
                evalDone   <= 1'b0;
                evalOffset <= 12'h000;
            end
        end
    end

    // ****************************************************************
    // Outputs: rate, channel lines, output gating
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            serialRate  <= SMSC_RATE_2M;
            channelMask <= 7'h1F;
        end else if (ce) begin
            serialRate  <= imsReg[SMSC_RATE_HI:SMSC_RATE_LO];
            channelMask <= smsc_chan_mask(
                               imsReg[SMSC_RATE_HI:SMSC_RATE_LO]);
        end
    end

    genvar s;
    generate
        for (s = 0; s < SMSC_STREAMS; s++) begin : gOut
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    serialOutEnable[s] <= 1'b0;
                end else if (ce) begin
                    serialOutEnable[s] <= odeSync[1]
                        | imsReg[SMSC_STBY_BIT];
                end
            end
        end
    endgenerate
endmodule // smsc_device

// *** include/smsc_pkg.sv ***
package smsc_pkg;
    // ****************************************************************
    // Device register map and fields
    // ****************************************************************
    localparam logic [7:0] SMSC_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] SMSC_ADDR_IMS     = 8'h01;
    localparam logic [7:0] SMSC_ADDR_FAR     = 8'h02;
    localparam logic [15:0] SMSC_RESET_VALUE = 16'h0000;
    localparam int SMSC_READY_BIT = 5;     // Block fill ready in control
    localparam int SMSC_CTRL_USED = 6;     // Control bits 5..0 exist
    localparam int SMSC_FILL_HI   = 9;     // Block fill value 9..5
    localparam int SMSC_FILL_LO   = 5;
    localparam int SMSC_BEGIN_BIT = 4;
    localparam int SMSC_STBY_BIT  = 3;
    localparam int SMSC_EVAL_BIT  = 2;
    localparam int SMSC_RATE_HI   = 1;
    localparam int SMSC_RATE_LO   = 0;
    localparam int SMSC_IMS_USED  = 10;    // Bits 15..10 unused
    localparam int SMSC_DONE_BIT  = 12;    // Evaluation done in FRAME_ALIGNMENT_RESULT
    localparam int SMSC_OFS_W     = 12;    // Offset bits 11..0
    localparam int SMSC_CM_LO_W   = 11;    // Connection memory bits 10..0
    localparam int SMSC_STREAMS   = 16;
    localparam int SMSC_FILL_FRAMES = 2;
    localparam int SMSC_IDLE_FRAMES = 1;

    // Serial rate codes
    typedef enum logic [1:0] {
        SMSC_RATE_2M = 2'h0,
        SMSC_RATE_4M = 2'h1,
        SMSC_RATE_8M = 2'h2,
        SMSC_RATE_RSV = 2'h3
    } smsc_rate_t;

    // Channel mask for the channel address lines valid at a rate
    function automatic logic [6:0] smsc_chan_mask(input logic [1:0] rate);
        case (rate)
            SMSC_RATE_2M: smsc_chan_mask = 7'h1F;
            SMSC_RATE_4M: smsc_chan_mask = 7'h3F;
            SMSC_RATE_8M: smsc_chan_mask = 7'h7F;
            default:      smsc_chan_mask = 7'h1F;
        endcase
    endfunction

    // ****************************************************************
    // Host register map (Wishbone byte addresses)
    // ****************************************************************
    localparam logic [3:0] SMSC_WB_CMD    = 4'h0;
    localparam logic [3:0] SMSC_WB_WDATA  = 4'h4;
    localparam logic [3:0] SMSC_WB_RDATA  = 4'h8;
    localparam logic [3:0] SMSC_WB_STATUS = 4'hC;
    localparam int SMSC_CMD_WRITE_BIT = 8;
    localparam int SMSC_ST_BUSY_BIT   = 0;
    localparam int SMSC_ST_REFUSE_BIT = 1;
endpackage

// *** include/smsc_bus_if.sv ***
`timescale 1ns/1ps
interface smsc_bus_if;
    logic        cs;          // One-cycle access strobe
    logic        we;          // Write when high
    logic [7:0]  addr;
    logic [15:0] wrData;
    logic [15:0] rdData;
    logic        ack;         // One-cycle answer
    logic        framePulse;  // Synchronised frame pulse

    modport device (input cs, we, addr, wrData,
                    output rdData, ack, framePulse);
    modport host   (output cs, we, addr, wrData,
                    input rdData, ack, framePulse);
endinterface

// *** verilog/smsc_host.sv ***
`timescale 1ns/1ps
module smsc_host
    import smsc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Device bus
    smsc_bus_if.host         bus
);
    // ****************************************************************
    // State
    // ****************************************************************
    logic [8:0]  cmdReg;
    logic [15:0] wdataReg;
    logic [15:0] rdataReg;
    logic        busy;
    logic        refused;
    logic [15:0] imsShadow;
    logic [1:0]  fillFrames;
    logic [1:0]  lowFrames;
    logic        wbTake;
    logic        cmdGo;
    logic        isIms;
    logic [15:0] outData;
    logic        badWrite;

    assign wbTake = wb_cyc_i & wb_stb_i & wb_ack_o;
    assign cmdGo  = wbTake & wb_we_i & (wb_adr_i == SMSC_WB_CMD)
                  & wb_sel_i[0] & ~busy;
    assign isIms  = (wb_dat_i[7:0] == SMSC_ADDR_IMS)
                  & wb_dat_i[SMSC_CMD_WRITE_BIT];
    // Unused high bits forced to zero for the mode register
    assign outData = isIms ? {{(16-SMSC_IMS_USED){1'b0}},
                              wdataReg[SMSC_IMS_USED-1:0]} : wdataReg;
    // Refuse mode writes that alter a fill up to the second of its three frame pulses, or retrigger too soon
    assign badWrite = isIms
        & (((fillFrames != 2'(SMSC_FILL_FRAMES))
            & imsShadow[SMSC_BEGIN_BIT]
            & wdataReg[SMSC_BEGIN_BIT]
            & (outData != imsShadow))
         | (~imsShadow[SMSC_EVAL_BIT] & outData[SMSC_EVAL_BIT]
            & (lowFrames <= 2'(SMSC_IDLE_FRAMES))));

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    // Answer one cycle after the request, drop ack afterwards
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            case (wb_adr_i)
                SMSC_WB_CMD:    wb_dat_o <= {23'h0, cmdReg};
                SMSC_WB_WDATA:  wb_dat_o <= {16'h0, wdataReg};
                SMSC_WB_RDATA:  wb_dat_o <= {16'h0, rdataReg};
                SMSC_WB_STATUS: wb_dat_o <= {30'h0, refused, busy};
                default:        wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Command and write data registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmdReg   <= 9'h000;
            wdataReg <= 16'h0000;
        end else if (ce) begin
            if (cmdGo) begin
                cmdReg <= wb_dat_i[8:0];
            end
            if (wbTake && wb_we_i && wb_adr_i == SMSC_WB_WDATA) begin
                if (wb_sel_i[0]) wdataReg[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) wdataReg[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ****************************************************************
    // Device access
    // ****************************************************************
    // One strobe per command, busy until the device answers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus.cs     <= 1'b0;
            bus.we     <= 1'b0;
            bus.addr   <= 8'h00;
            bus.wrData <= 16'h0000;
            busy       <= 1'b0;
            rdataReg   <= 16'h0000;
        end else if (ce) begin
            bus.cs <= 1'b0;
            if (cmdGo && !badWrite) begin
                bus.cs     <= 1'b1;
                bus.we     <= wb_dat_i[SMSC_CMD_WRITE_BIT];
                bus.addr   <= wb_dat_i[7:0];
                bus.wrData <= outData;
                busy       <= 1'b1;
            end else if (busy && bus.ack) begin
                busy <= 1'b0;
                if (!bus.we) rdataReg <= bus.rdData;
            end
        end
    end

    // Refusal flag: set wins over a clear by writing one to it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            refused <= 1'b0;
        end else if (ce) begin
            if (cmdGo && badWrite) begin
                refused <= 1'b1;
            end else if (wbTake && wb_we_i && wb_adr_i == SMSC_WB_STATUS
                         && wb_sel_i[0] && wb_dat_i[SMSC_ST_REFUSE_BIT]) begin
                refused <= 1'b0;
            end
        end
    end

    // Shadow of the mode register and frame counts after changes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            imsShadow  <= SMSC_RESET_VALUE;
            fillFrames <= 2'h0;
            lowFrames  <= 2'h3;     // First start is never a retrigger
        end else if (ce) begin
            if (cmdGo && !badWrite && isIms) begin
                imsShadow <= outData;
                // New fill also after the device cleared begin itself
                if (outData[SMSC_BEGIN_BIT] && (!imsShadow[SMSC_BEGIN_BIT]
                    || fillFrames == 2'(SMSC_FILL_FRAMES)))
                    fillFrames <= 2'h0;
                if (!outData[SMSC_EVAL_BIT] && imsShadow[SMSC_EVAL_BIT])
                    lowFrames <= 2'h0;
            end else if (bus.framePulse) begin
                if (fillFrames != 2'(SMSC_FILL_FRAMES))
                    fillFrames <= fillFrames + 2'h1;
                if (lowFrames != 2'h3)
                    lowFrames <= lowFrames + 2'h1;
            end
        end
    end
endmodule // smsc_host

// *** test/smsc_check_sva.sv ***
`timescale 1ns/1ps
module smsc_check_sva
    import smsc_pkg::*;
(
    // Clock, reset and device bus
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        cs,
    input wire logic        we,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wrData,
    input wire logic        ack,
    input wire logic        framePulse,
    // Device pins and outputs
    input wire logic        outputDriveEnablePin,
    input wire logic [15:0] serialOutEnable,
    input wire logic [1:0]  serialRate,
    input wire logic [6:0]  channelMask,
    input wire logic        cmWrite,
    input wire logic [10:0] cmAddr,
    input wire logic [15:0] cmData,
    input wire logic        fillBusy,
    input wire logic        evalRunning,
    input wire logic        measDone
);
    // ********************
    // Mirrors and checks
    // ********************
    logic       stby;
    logic [4:0] fillVal;
    logic [2:0] fpCnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Mirror of standby and fill value as written
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stby    <= 1'b0;
            fillVal <= 5'h00;
        end else if (cs && we && addr == SMSC_ADDR_IMS) begin
            stby <= wrData[SMSC_STBY_BIT];
            if (wrData[SMSC_BEGIN_BIT])
                fillVal <= wrData[9:5];
        end
    end
    // Frame pulses seen during one fill
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            fpCnt <= 3'h0;
        else if (!fillBusy)
            fpCnt <= 3'h0;
        else if (framePulse)
            fpCnt <= fpCnt + 3'h1;
    end
    AST_ACK_NEXT: assert property (cs |=> ack)
        else $error("no answer after strobe");
    AST_ACK_ONE: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    AST_HIGH_Z: assert property ((!outputDriveEnablePin && !stby)[*4]
        |-> serialOutEnable == 16'h0000) else $error("outputs not off");
    AST_DRIVE_ON: assert property (outputDriveEnablePin[*4]
        |-> serialOutEnable == 16'hFFFF) else $error("outputs not on");
    AST_FILL_HI: assert property (cmWrite |-> cmData[15:11] == fillVal)
        else $error("fill value wrong");
    AST_FILL_LO: assert property (cmWrite |-> cmData[10:0] == 11'h000)
        else $error("low memory bits not cleared");
    AST_MASK: assert property (channelMask == (serialRate == 2'h1 ? 7'h3F :
        serialRate == 2'h2 ? 7'h7F : 7'h1F)) else $error("mask wrong");
    AST_CHAN_RANGE: assert property (cmWrite
        |-> (cmAddr[6:0] & ~channelMask) == 7'h00) else $error("chan range");
    AST_FILL_START: assert property ($rose(fillBusy) |-> ($past(cs) ||
        $past(cs, 2) || $past(cs, 3)) && addr == SMSC_ADDR_IMS
        && wrData[SMSC_BEGIN_BIT]) else $error("fill without begin");
    AST_FILL_FRAMES: assert property (fillBusy |-> fpCnt <= 3'h3)
        else $error("fill too long");
    AST_EVAL_STOP: assert property ($rose(measDone) && evalRunning
        |-> ##[1:2] !evalRunning) else $error("evaluation not stopped");
endmodule // smsc_check_sva

// *** test/tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb
    import smsc_pkg::*;
;
    // ********************
    // Stimulus and checks
    // ********************
    logic clk_sys = 0, nrst = 0, ce = 1, framePin = 0;
    logic outputDriveEnablePin = 0, measDone = 0, cmWrite, fillBusy;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, evalRunning;
    logic [3:0]  wb_adr_i = 0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic [15:0] serialOutEnable, cmData;
    logic [11:0] measOffset = 12'hA5C;
    logic [10:0] cmAddr;
    logic [6:0]  channelMask;
    logic [1:0]  serialRate;
    int          n_errors = 0, compares = 0, nWr = 0, fCnt = 0, nBase;
    smsc_bus_if busIf();
    smsc_device smsc_device_i (.clk_sys, .nrst, .ce, .bus(busIf), .framePin,
        .outputDriveEnablePin, .serialOutEnable, .serialRate, .channelMask,
        .evalRunning, .measDone, .measOffset, .cmWrite, .cmAddr, .cmData,
        .fillBusy);
    smsc_host smsc_host_i (.clk_sys, .nrst, .ce, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .bus(busIf));
    smsc_check_sva smsc_check_sva_i (.clk_sys, .nrst, .cs(busIf.cs),
        .we(busIf.we), .addr(busIf.addr), .wrData(busIf.wrData),
        .ack(busIf.ack), .framePulse(busIf.framePulse), .outputDriveEnablePin,
        .serialOutEnable, .serialRate, .channelMask, .cmWrite, .cmAddr,
        .cmData, .fillBusy, .evalRunning, .measDone);
    always #5 clk_sys = ~clk_sys;
    // Frame pulse every 2200 cycles, fill writes counted
    always @(posedge clk_sys) begin
        fCnt <= (fCnt == 2199) ? 0 : fCnt + 1;
        framePin <= (fCnt == 0);
        if (cmWrite === 1'b1) nWr <= nWr + 1;
    end
    // One classic Wishbone cycle, held until ack
    task automatic wbx(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Device register access through the host
    task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        wbx(1'b1, SMSC_WB_WDATA, {16'h0000, d});
        wbx(1'b1, SMSC_WB_CMD, {23'h000000, w, a});
        rd = 32'h1;
        while (rd[SMSC_ST_BUSY_BIT] !== 1'b0 && n < 50) begin
            wbx(1'b0, SMSC_WB_STATUS, 32'h0);
            n++;
        end
        if (!w) wbx(1'b0, SMSC_WB_RDATA, 32'h0);
    endtask
    task automatic waitBusy(input logic v);
        int n;
        n = 0;
        while (fillBusy !== v && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        dev(0, SMSC_ADDR_IMS, 0); `CHK(rd[15:0], SMSC_RESET_VALUE)
        dev(0, SMSC_ADDR_FAR, 0); `CHK(rd[15:0], 16'h0000)
        `CHK(serialOutEnable, 16'h0000)
        for (int r = 0; r < 4; r++) begin
            dev(1, SMSC_ADDR_IMS, 16'hFC00 | 16'(r));
            dev(0, SMSC_ADDR_IMS, 0); `CHK(rd[15:0], 16'(r))
            `CHK(serialRate, 2'(r))
            `CHK(channelMask, r == 1 ? 7'h3F : r == 2 ? 7'h7F : 7'h1F)
        end
        dev(1, SMSC_ADDR_IMS, 16'h0008); `CHK(serialOutEnable, 16'hFFFF)
        dev(1, SMSC_ADDR_IMS, 16'h0000); `CHK(serialOutEnable, 16'h0000)
        outputDriveEnablePin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        `CHK(serialOutEnable, 16'hFFFF)
        outputDriveEnablePin <= 1'b0;
        dev(1, SMSC_ADDR_IMS, 16'h0004); `CHK(evalRunning, 1'b1)
        measDone <= 1'b1;
        repeat (4) @(posedge clk_sys);
        `CHK(evalRunning, 1'b0)
        dev(0, SMSC_ADDR_FAR, 0); `CHK(rd[15:0], 16'h1A5C)
        measDone <= 1'b0;
        dev(1, SMSC_ADDR_IMS, 16'h0000);
        dev(0, SMSC_ADDR_FAR, 0); `CHK(rd[15:0], 16'h0000)
        dev(1, SMSC_ADDR_IMS, 16'h0004);
        `CHK(rd[SMSC_ST_REFUSE_BIT], 1'b1)
        wbx(1'b1, SMSC_WB_STATUS, 32'h2); `CHK(evalRunning, 1'b0)
        dev(1, SMSC_ADDR_CONTROL, 16'h0020);
        nBase = nWr;
        dev(1, SMSC_ADDR_IMS, 16'h02B0);
        waitBusy(1'b1);
        waitBusy(1'b0);
        `CHK(nWr - nBase, 1024)
        dev(0, SMSC_ADDR_IMS, 0); `CHK(rd[15:0], 16'h02A0)
        dev(1, SMSC_ADDR_IMS, 16'h02B0);
        waitBusy(1'b1);
        dev(1, SMSC_ADDR_IMS, 16'h02A0); `CHK(fillBusy, 1'b0)
        dev(1, SMSC_ADDR_IMS, 16'h02B0);
        waitBusy(1'b1);
        dev(1, SMSC_ADDR_IMS, 16'h02B8);
        `CHK(rd[SMSC_ST_REFUSE_BIT], 1'b1)
        wbx(1'b1, SMSC_WB_STATUS, 32'h2); `CHK(fillBusy, 1'b1)
        dev(1, SMSC_ADDR_CONTROL, 16'h0000); `CHK(fillBusy, 1'b0)
        dev(0, SMSC_ADDR_IMS, 0); `CHK(rd[15:0], 16'h02A0)
        dev(1, SMSC_ADDR_IMS, 16'h02B0);
        repeat (2300) @(posedge clk_sys);
        `CHK(fillBusy, 1'b0)
        finish_test();
    end
endmodule // tb
